// *** core/irs_pkg.sv ***
// Purpose: Shared constants and types for the interrupt pin routing block
// Assumes: Index-addressed configuration port, one 50 MHz clock
// Notes:   Route codes follow one table for every interrupt-select field
package irs_pkg;

  // Configuration index values of the routing registers
  localparam logic [7:0] DISK_PRN_ROUTE_IDX = 8'h27;
  localparam logic [7:0] SERIAL_ROUTE_IDX   = 8'h28;
  localparam logic [7:0] EXT_ROUTE_IDX      = 8'h29;

  // Values after reset
  localparam logic [7:0] ROUTE_RESET        = 8'h00;
  localparam logic [7:0] INDEX_RESET        = 8'h00;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // Field positions: upper and lower select nibbles
  localparam int         HI_NIB_LSB         = 4;
  localparam int         LO_NIB_LSB         = 0;
  localparam int         NIB_W              = 4;

  // Route codes
  localparam logic [3:0] CODE_NONE          = 4'h0;
  localparam logic [3:0] CODE_RESERVED      = 4'h7;
  localparam logic [3:0] CODE_SHARE         = 4'hf;

  // Pins: codes 1..6 and 8..14, one pin each
  localparam int         NUM_PINS           = 13;
  localparam int         LOW_PIN_GROUP      = 6;

  // Interrupt sources, lowest index wins a pin on a conflict
  localparam int         NUM_SRC            = 5;
  localparam int         SRC_DISK           = 0;
  localparam int         SRC_PRINTER        = 1;
  localparam int         SRC_SERIAL1        = 2;
  localparam int         SRC_SERIAL2        = 3;
  localparam int         SRC_EXT            = 4;

  // Synchroniser depth for pin inputs
  localparam int         SYNC_STAGES        = 2;

  // One host access on the configuration port
  typedef struct packed {
    logic       index_wr;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] wdata;
  } irs_cfg_req_s;

  // One interrupt source after gating: where it goes and what it drives
  typedef struct packed {
    logic [3:0] code;
    logic       enable;
    logic       level;
  } irs_src_s;

  typedef irs_src_s [NUM_SRC-1:0] irs_src_vec_t;

endpackage : irs_pkg

// *** core/irs_pin_mux.sv ***
// Purpose: Decides what one interrupt pin shows from all routed sources
// Assumes: Each source arrives with its own enable bit, which is applied here
// Notes:   Lowest source index wins when software routes two to one pin
`timescale 1ns/1ns
module irs_pin_mux #(
  parameter logic [3:0] PIN_CODE = 4'h1
) (
  // Routed sources
  input  wire irs_pkg::irs_src_vec_t srcs_in,
  // Pin drive decision
  output logic                       drive_out,
  output logic                       level_out
);

  always_comb begin
    drive_out = 1'b0;
    level_out = 1'b0;
    // Walk downward so the lowest matching source is kept
    for (int s = irs_pkg::NUM_SRC - 1; s >= 0; s--) begin
      if (srcs_in[s].code == PIN_CODE && srcs_in[s].enable) begin
        drive_out = 1'b1;
        level_out = srcs_in[s].level;
      end
    end
  end

endmodule : irs_pin_mux

// *** core/irs_route_top.sv ***
// Purpose: Interrupt pin routing with serial-port sharing and an external input
// Assumes: Host drives the configuration port from logic on clk_sys_in;
//          the external interrupt arrives on a pin from outside the clock
// Notes:   Pin outputs are registered; undriven pins have their enable high
//
// Overview of operation
// RULE1: Routing register reached only in config mode, matching index
// RULE2: Routing register resets to all zeros
// RULE3: Low nibble picks the external interrupt's pin
// RULE4: Upper nibble reserved, always reads zero
// RULE5: Unselected interrupt pins stay high impedance
// RULE6: Serial pin follows interrupt only when enable set
// RULE7: Sharing merges both serial sources onto first pin
// RULE8: Host must not route two sources together
// RULE9: Host routes first port, then all ones for sharing
// RULE10: Serial register: upper nibble first, lower second
// RULE11: External level passes unchanged, not latched or inverted
`timescale 1ns/1ns
module irs_route_top (
  // Clock and reset
  input  wire logic                          clk_sys_in,
  input  wire logic                          rst_in,
  // Configuration port
  input  wire logic                          cfg_mode_in,
  input  wire irs_pkg::irs_cfg_req_s         cfg_req_in,
  output logic [7:0]                         cfg_rdata_out,
  output logic                               cfg_rvalid_out,
  output logic [7:0]                         config_index_pointer_out,
  // Interrupt sources
  input  wire logic                          disk_irq_in,
  input  wire logic                          printer_irq_in,
  input  wire logic                          first_serial_port_irq_in,
  input  wire logic                          first_serial_port_oe_in,
  input  wire logic                          second_serial_port_irq_in,
  input  wire logic                          second_serial_port_oe_in,
  input  wire logic                          external_interrupt_input_in,
  // Interrupt pins
  output logic [irs_pkg::NUM_PINS-1:0]       irq_pin_out,
  output logic [irs_pkg::NUM_PINS-1:0]       irq_pin_oe_n_out,
  // State for observation
  output logic                               share_mode_out
);

  // Configuration state
  logic [7:0]                         config_index_pointer;
  logic [7:0]                         disk_and_printer_irq_route_select;
  logic [7:0]                         serial_irq_route_select;
  logic [irs_pkg::NIB_W-1:0]          ext_route_code;
  logic [7:0]                         cfg_rdata;
  logic                               cfg_rvalid;

  // External interrupt synchroniser
  logic [irs_pkg::SYNC_STAGES-1:0]    ext_sync;
  logic                               ext_level;

  // Decoded accesses
  wire                                idx_wr_ok;
  wire                                data_wr_ok;
  wire                                data_rd_ok;
  wire                                sel_disk_prn;
  wire                                sel_serial;
  wire                                sel_ext;
  wire [7:0]                          ext_route_view;
  wire [7:0]                          next_rdata;

  // Source routing
  wire [3:0]                          serial1_code;
  wire [3:0]                          serial2_code;
  wire                                share_mode;
  wire                                serial1_enable;
  wire                                serial1_level;
  irs_pkg::irs_src_vec_t              srcs;

  // Pin decisions
  logic [irs_pkg::NUM_PINS-1:0]       next_pin_drive;
  logic [irs_pkg::NUM_PINS-1:0]       next_pin_level;

  // Configuration port decode
  assign idx_wr_ok    = cfg_mode_in && cfg_req_in.index_wr;
  assign data_wr_ok   = cfg_mode_in && cfg_req_in.data_wr;        // [RULE1]
  assign data_rd_ok   = cfg_mode_in && cfg_req_in.data_rd;        // [RULE1]
  assign sel_disk_prn = config_index_pointer == irs_pkg::DISK_PRN_ROUTE_IDX;
  assign sel_serial   = config_index_pointer == irs_pkg::SERIAL_ROUTE_IDX;
  assign sel_ext      = config_index_pointer == irs_pkg::EXT_ROUTE_IDX;   // [RULE1]

  // Reserved upper nibble is never stored, so it reads zero
  assign ext_route_view = {{irs_pkg::NIB_W{1'b0}}, ext_route_code};   // [RULE4]

  assign next_rdata = sel_disk_prn ? disk_and_printer_irq_route_select :
                      sel_serial   ? serial_irq_route_select :
                      sel_ext      ? ext_route_view :                 // [RULE1]
                                     irs_pkg::READ_UNMAPPED;

  // Index pointer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      config_index_pointer <= irs_pkg::INDEX_RESET;
    end else if (idx_wr_ok) begin
      config_index_pointer <= cfg_req_in.wdata;
    end
  end

  // Routing registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      disk_and_printer_irq_route_select <= irs_pkg::ROUTE_RESET;
      serial_irq_route_select           <= irs_pkg::ROUTE_RESET;
      ext_route_code                    <= irs_pkg::ROUTE_RESET[irs_pkg::NIB_W-1:0]; // [RULE2]
    end else if (data_wr_ok) begin
      if (sel_disk_prn) begin
        disk_and_printer_irq_route_select <= cfg_req_in.wdata;
      end
      if (sel_serial) begin
        serial_irq_route_select <= cfg_req_in.wdata;
      end
      if (sel_ext) begin
        ext_route_code <= cfg_req_in.wdata[irs_pkg::LO_NIB_LSB +: irs_pkg::NIB_W]; // [RULE1]
      end
    end
  end

  // Read data, answered one cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cfg_rdata  <= irs_pkg::READ_UNMAPPED;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= data_rd_ok;
      if (data_rd_ok) begin
        cfg_rdata <= next_rdata;
      end
    end
  end

  // Two-stage synchroniser for the pin input
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ext_sync <= '0;
    end else begin
      ext_sync <= {ext_sync[irs_pkg::SYNC_STAGES-2:0], external_interrupt_input_in};
    end
  end

  assign ext_level = ext_sync[irs_pkg::SYNC_STAGES-1];   // [RULE11]

  // Serial routing and sharing
  assign serial1_code = serial_irq_route_select[irs_pkg::HI_NIB_LSB +: irs_pkg::NIB_W];
  assign serial2_code = serial_irq_route_select[irs_pkg::LO_NIB_LSB +: irs_pkg::NIB_W]; // [RULE10]
  assign share_mode   = serial2_code == irs_pkg::CODE_SHARE;

  assign serial1_enable = share_mode ? (first_serial_port_oe_in || second_serial_port_oe_in)
                                     : first_serial_port_oe_in;                 // [RULE7]
  assign serial1_level  = share_mode ?
                          ((first_serial_port_oe_in && first_serial_port_irq_in) ||
                           (second_serial_port_oe_in && second_serial_port_irq_in))
                                     : first_serial_port_irq_in;                // [RULE7]

  // Source table fed to every pin
  assign srcs[irs_pkg::SRC_DISK].code      =
    disk_and_printer_irq_route_select[irs_pkg::HI_NIB_LSB +: irs_pkg::NIB_W];
  assign srcs[irs_pkg::SRC_DISK].enable    = 1'b1;
  assign srcs[irs_pkg::SRC_DISK].level     = disk_irq_in;
  assign srcs[irs_pkg::SRC_PRINTER].code   =
    disk_and_printer_irq_route_select[irs_pkg::LO_NIB_LSB +: irs_pkg::NIB_W];
  assign srcs[irs_pkg::SRC_PRINTER].enable = 1'b1;
  assign srcs[irs_pkg::SRC_PRINTER].level  = printer_irq_in;
  assign srcs[irs_pkg::SRC_SERIAL1].code   = serial1_code;                     // [RULE10]
  assign srcs[irs_pkg::SRC_SERIAL1].enable = serial1_enable;                   // [RULE6]
  assign srcs[irs_pkg::SRC_SERIAL1].level  = serial1_level;                    // [RULE6]
  // Share code selects no pin, so the second serial pin stays undriven
  assign srcs[irs_pkg::SRC_SERIAL2].code   = serial2_code;                     // [RULE7]
  assign srcs[irs_pkg::SRC_SERIAL2].enable = second_serial_port_oe_in;         // [RULE6]
  assign srcs[irs_pkg::SRC_SERIAL2].level  = second_serial_port_irq_in;        // [RULE6]
  assign srcs[irs_pkg::SRC_EXT].code       = ext_route_code;                   // [RULE3]
  assign srcs[irs_pkg::SRC_EXT].enable     = 1'b1;
  assign srcs[irs_pkg::SRC_EXT].level      = ext_level;                        // [RULE11]

  // One decision per pin; code 7 and code 15 have no pin
  generate
    for (genvar p = 0; p < irs_pkg::NUM_PINS; p++) begin : g_pin
      localparam logic [3:0] PIN_CODE = (p < irs_pkg::LOW_PIN_GROUP) ? 4'(p + 1) : 4'(p + 2);

      // Conflicting routes are resolved by priority, never driven twice
      irs_pin_mux #(
        .PIN_CODE  (PIN_CODE)
      ) u_pin_mux (
        .srcs_in   (srcs),
        .drive_out (next_pin_drive[p]),                                        // [RULE8]
        .level_out (next_pin_level[p])
      );
    end
  endgenerate

  // Registered pin drivers; enable high means high impedance
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_pin_out      <= '0;
      irq_pin_oe_n_out <= '1;                                                  // [RULE5]
    end else begin
      irq_pin_out      <= next_pin_level & next_pin_drive;
      irq_pin_oe_n_out <= ~next_pin_drive;                                     // [RULE5]
    end
  end

  assign cfg_rdata_out            = cfg_rdata;
  assign cfg_rvalid_out           = cfg_rvalid;
  assign config_index_pointer_out = config_index_pointer;
  assign share_mode_out           = share_mode;

endmodule : irs_route_top

// *** bench/irs_pic_model.sv ***
// Purpose: Receiving end of the interrupt pins (system interrupt controller)
// Assumes: Pins resolved from level and active-low enable
// Notes:   Released lines float, no pull assumed
`timescale 1ns/1ns
module irs_pic_model (
  // Pin drive from the routing block
  input  wire logic [irs_pkg::NUM_PINS-1:0] pin_in,
  input  wire logic [irs_pkg::NUM_PINS-1:0] pin_oe_n_in,
  // Level seen on each line
  output logic [irs_pkg::NUM_PINS-1:0]      line_out
);
  for (genvar i = 0; i < irs_pkg::NUM_PINS; i++) begin : g_line
    assign line_out[i] = pin_oe_n_in[i] ? 1'bz : pin_in[i];
  end
endmodule : irs_pic_model

// *** bench/irs_route_sva.sv ***
// Purpose: Port checker for the routing block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the top
`timescale 1ns/1ns
module irs_route_sva (
  input wire logic                    clk_sys_in,
  input wire logic                    rst_in,
  input wire logic                    cfg_mode_in,
  input wire irs_pkg::irs_cfg_req_s   cfg_req_in,
  input wire logic [7:0]              cfg_rdata_out,
  input wire logic                    cfg_rvalid_out,
  input wire logic [7:0]              config_index_pointer_out,
  input wire logic [irs_pkg::NUM_PINS-1:0] irq_pin_out,
  input wire logic [irs_pkg::NUM_PINS-1:0] irq_pin_oe_n_out,
  input wire logic                    share_mode_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  wire rd_take = cfg_mode_in && cfg_req_in.data_rd;
  wire ix_take = cfg_mode_in && cfg_req_in.index_wr;
  wire mapped  = (config_index_pointer_out >= irs_pkg::DISK_PRN_ROUTE_IDX) &&
                 (config_index_pointer_out <= irs_pkg::EXT_ROUTE_IDX);
  chk_rd_answer: assert property (rd_take |=> cfg_rvalid_out)
    else $error("read not answered");
  chk_no_stray: assert property (!rd_take |=> !cfg_rvalid_out)
    else $error("answer without accepted read");
  chk_idx_load: assert property (
    ix_take |=> config_index_pointer_out == $past(cfg_req_in.wdata))
    else $error("index not loaded");
  chk_idx_hold: assert property (!ix_take |=> $stable(config_index_pointer_out))
    else $error("index changed without write");
  chk_rsvd_zero: assert property (
    rd_take && config_index_pointer_out == irs_pkg::EXT_ROUTE_IDX |=> cfg_rdata_out[7:4] == 4'h0)
    else $error("reserved bits not zero");
  chk_unmapped_read: assert property (
    rd_take && !mapped |=> cfg_rdata_out == irs_pkg::READ_UNMAPPED)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!cfg_rvalid_out |-> $stable(cfg_rdata_out))
    else $error("read data moved");
  chk_undriven_low: assert property ((irq_pin_out & irq_pin_oe_n_out) == '0)
    else $error("released pin shows level");
  chk_reset_state: assert property ($fell(rst_in) |-> (&irq_pin_oe_n_out) && !share_mode_out)
    else $error("pins not released after reset");
  cover property (rd_take);
  cover property (share_mode_out && !(&irq_pin_oe_n_out));
  cover property (ix_take && !mapped);
endmodule : irs_route_sva
bind irs_route_top irs_route_sva chk_i (.clk_sys_in, .rst_in, .cfg_mode_in, .cfg_req_in,
  .cfg_rdata_out, .cfg_rvalid_out, .config_index_pointer_out, .irq_pin_out,
  .irq_pin_oe_n_out, .share_mode_out);

// *** bench/irq_pin_routing_share_tb.sv ***
// Purpose: Self-checking bench for the routing block
// Assumes: Host access by index then data strobes
// Notes:   Pin levels judged through the interrupt controller model
`timescale 1ns/1ns
module irq_pin_routing_share_tb;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic cfg_mode_in = 1'b1;
  irs_pkg::irs_cfg_req_s cfg_req_in = '0;
  logic [7:0] rdata, ptr;
  logic rvalid, share;
  logic dsk = 1'b0, prn = 1'b0, i1 = 1'b0, o1 = 1'b0, i2 = 1'b0, o2 = 1'b0, ext = 1'b0;
  logic [12:0] pin, oe_n, line;
  int errors = 0;
  int samples_checked = 0;
  initial forever #10 clk_sys_in = ~clk_sys_in;
  irs_route_top dut (.clk_sys_in, .rst_in, .cfg_mode_in, .cfg_req_in, .cfg_rdata_out(rdata),
    .cfg_rvalid_out(rvalid), .config_index_pointer_out(ptr), .disk_irq_in(dsk),
    .printer_irq_in(prn), .first_serial_port_irq_in(i1), .first_serial_port_oe_in(o1),
    .second_serial_port_irq_in(i2), .second_serial_port_oe_in(o2),
    .external_interrupt_input_in(ext), .irq_pin_out(pin), .irq_pin_oe_n_out(oe_n),
    .share_mode_out(share));
  irs_pic_model pic (.pin_in(pin), .pin_oe_n_in(oe_n), .line_out(line));
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic op(input logic [2:0] st, input logic [7:0] d);
    @(posedge clk_sys_in) cfg_req_in <= {st, d};
    @(posedge clk_sys_in) cfg_req_in <= '0;
  endtask : op
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    op(3'b100, idx);
    op(3'b010, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    op(3'b100, idx);
    #1 chk({5'h00, ptr}, {5'h00, idx}, "index");
    op(3'b001, 8'h00);
    #1 chk({4'h0, rvalid, rdata}, {5'h01, exp}, "read");
  endtask : rd
  task automatic pins(input logic [12:0] drv, input logic [12:0] lvl, input int n);
    logic [12:0] e;
    for (int i = 0; i < 13; i++) e[i] = drv[i] ? lvl[i] : 1'bz;
    repeat (n) @(posedge clk_sys_in);
    #1 chk(line, e, "pins");
  endtask : pins
  task automatic t_reset();
    rd(irs_pkg::EXT_ROUTE_IDX, 8'h00);
    rd(irs_pkg::SERIAL_ROUTE_IDX, 8'h00);
    pins('0, '0, 1);
  endtask : t_reset
  task automatic t_ext();
    logic [3:0] c;
    for (int p = 0; p < 13; p++) begin
      c = (p < 6) ? 4'(p + 1) : 4'(p + 2);
      wr(irs_pkg::EXT_ROUTE_IDX, {4'ha, c});
      rd(irs_pkg::EXT_ROUTE_IDX, {4'h0, c});
      @(posedge clk_sys_in) ext <= 1'b1;
      pins(13'h1 << p, 13'h1 << p, 3);
      @(posedge clk_sys_in) ext <= 1'b0;
      pins(13'h1 << p, '0, 3);
    end
    wr(irs_pkg::EXT_ROUTE_IDX, 8'h07);
    pins('0, '0, 2);
    wr(irs_pkg::EXT_ROUTE_IDX, 8'h0f);
    pins('0, '0, 2);
    rd(8'h2a, irs_pkg::READ_UNMAPPED);
    @(posedge clk_sys_in) cfg_mode_in <= 1'b0;
    wr(irs_pkg::EXT_ROUTE_IDX, 8'h01);
    op(3'b001, 8'h00);
    #1 chk({12'h0, rvalid}, 13'h0, "read outside mode");
    chk({5'h00, ptr}, 13'h02a, "index outside mode");
    @(posedge clk_sys_in) cfg_mode_in <= 1'b1;
    rd(irs_pkg::EXT_ROUTE_IDX, 8'h0f);
    wr(irs_pkg::EXT_ROUTE_IDX, 8'h00);
  endtask : t_ext
  task automatic t_disk();
    wr(irs_pkg::DISK_PRN_ROUTE_IDX, 8'h34);
    rd(irs_pkg::DISK_PRN_ROUTE_IDX, 8'h34);
    rd(irs_pkg::EXT_ROUTE_IDX, 8'h00);
    @(posedge clk_sys_in) {dsk, prn} <= 2'b10;
    pins(13'h00c, 13'h004, 2);
    @(posedge clk_sys_in) {dsk, prn} <= 2'b01;
    pins(13'h00c, 13'h008, 2);
    // Mid-run reset must clear routes written since power-up
    wr(irs_pkg::EXT_ROUTE_IDX, 8'h09);
    @(posedge clk_sys_in) rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    pins('0, '0, 1);
    chk({5'h00, ptr}, {5'h00, irs_pkg::INDEX_RESET}, "index reset");
    rd(irs_pkg::EXT_ROUTE_IDX, irs_pkg::ROUTE_RESET);
    rd(irs_pkg::DISK_PRN_ROUTE_IDX, irs_pkg::ROUTE_RESET);
  endtask : t_disk
  task automatic t_serial(input logic sh);
    logic [3:0] k;
    wr(irs_pkg::SERIAL_ROUTE_IDX, 8'h10);
    wr(irs_pkg::SERIAL_ROUTE_IDX, sh ? 8'h1f : 8'h12);
    #1 chk({12'h0, share}, {12'h0, sh}, "share flag");
    for (int j = 0; j < 16; j++) begin
      k = 4'(j);
      @(posedge clk_sys_in) {o1, i1, o2, i2} <= k;
      if (sh) pins({12'h0, k[3] | k[1]}, {12'h0, (k[3] & k[2]) | (k[1] & k[0])}, 2);
      else pins({11'h0, k[1], k[3]}, {11'h0, k[0], k[2]}, 2);
    end
  endtask : t_serial
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_reset();
    t_ext();
    t_disk();
    t_serial(1'b0);
    t_serial(1'b1);
    tally_and_finish();
  end
endmodule : irq_pin_routing_share_tb
